// *** design/reset_state_register_bank.sv ***
// Register bank that loads per-class reset values, with an APB slave
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module reset_state_register_bank (
    input wire logic pclk, // Core clock, 50 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire reset_bank_pkg::apb_req_t apb_req, // APB request
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic [31:0] prdata, // APB read data
    input wire reset_bank_pkg::reset_class_t reset_class, // Class
    input wire reset_bank_pkg::reset_cond_t reset_cond, // Cond bits
    input wire reset_bank_pkg::wake_irq_t wake_irq, // Wake source
    input wire logic [20:0] pc_now, // Current program counter
    input wire logic pins_free, // Oscillator frees port A 6,7
    input wire logic [7:0] port_a_in, // Port A pin levels
    output logic pc_load, // Pulse: load pc_vector
    output logic [20:0] pc_vector, // Interrupt vector address
    output logic [7:0] port_a_latch_out, // Port A latch
    output logic [7:0] port_a_dir_out // Port A direction
);
    import reset_bank_pkg::*;

    bank_t regs_q;
    bank_t regs_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pc_load_q;
    logic pc_load_d;
    logic [20:0] pc_vector_q;
    logic [20:0] pc_vector_d;

    logic [5:0] idx;
    logic idx_ok;
    logic setup_rd;
    logic access_wr;
    logic any_class;
    logic irq_wake;
    logic vec_high;
    logic vec_low;

    // Applies one reset pattern: keep, load, or take a condition bit
    function automatic logic [7:0] rst_apply(
        input logic [7:0] old,
        input logic [7:0] val,
        input logic [7:0] keep,
        input logic [7:0] qmask,
        input logic [7:0] q,
        input logic [7:0] impl
    );
        logic [7:0] r;
        r = (old & keep & ~qmask) | (val & ~keep & ~qmask) | (q & qmask);
        return r & impl;
    endfunction

    // Port A bits 6 and 7 vanish unless the oscillator frees them
    function automatic logic [7:0] pa_mask(input logic free);
        return free ? 8'hff : ~PA_FREE_MASK;
    endfunction

    // Read view of one register, with all absent bits forced low
    function automatic logic [7:0] rd_val(
        input bank_t r,
        input int i,
        input logic [7:0] pins,
        input logic free
    );
        logic [7:0] v;
        v = (i == IDX_PA_PINS) ? pins : r[i];
        v = v & IMPL[i];
        if (i == IDX_PA_LAT || i == IDX_PA_DIR || i == IDX_PA_PINS) begin
            v = v & pa_mask(free);
        end
        return v;
    endfunction

    assign idx = apb_req.paddr[7:2];
    assign idx_ok = (idx < 6'(NREG)) && (apb_req.paddr[1:0] == 2'b00);
    assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign access_wr = apb_req.psel && apb_req.penable
                       && apb_req.pwrite && idx_ok;
    assign any_class = reset_class.por || reset_class.bor
                       || reset_class.master_clear_pin || reset_class.wake;
    assign irq_wake = reset_class.wake && wake_irq.valid;
    assign vec_high = irq_wake && wake_irq.high
                      && regs_q[IDX_IRQ_CTL][GIE_H_BIT];
    assign vec_low = irq_wake && !wake_irq.high
                     && regs_q[IDX_IRQ_CTL][GIE_L_BIT];

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = apb_req.psel && apb_req.penable && !idx_ok;
    assign prdata = prdata_q;
    assign pc_load = pc_load_q;
    assign pc_vector = pc_vector_q;
    assign port_a_latch_out = regs_q[IDX_PA_LAT] & pa_mask(pins_free);
    assign port_a_dir_out = regs_q[IDX_PA_DIR] & pa_mask(pins_free);

    always_comb begin
        logic [7:0] v;
        logic [7:0] k;
        logic [7:0] qm;
        logic [7:0] q;
        v = 8'h00;
        k = 8'h00;
        qm = 8'h00;
        q = 8'h00;
        regs_d = regs_q;
        pc_load_d = 1'b0;
        pc_vector_d = pc_vector_q;
        if (any_class) begin
            // A reset class outranks a bus write in the same cycle
            for (int i = 0; i < NREG; i++) begin
                qm = 8'h00;
                q = 8'h00;
                if (reset_class.wake) begin
                    k = 8'hff;
                    v = 8'h00;
                    if (i == IDX_PR2) begin
                        k = 8'h00;
                        v = 8'hff;
                    end
                    if (i == IDX_OSC) begin
                        qm = OSC_Q_WK;
                        q = reset_cond.osc;
                    end
                    if (i == IDX_RCAUSE) begin
                        qm = RC_Q_WK;
                        q = reset_cond.cause;
                    end
                end else if (reset_class.master_clear_pin) begin
                    k = MC_K[i];
                    v = (i == IDX_RCAUSE) ? 8'h00 : POR_V[i];
                    if (i == IDX_OSC) begin
                        qm = OSC_Q_MC;
                        q = reset_cond.osc;
                    end
                    if (i == IDX_RCAUSE) begin
                        qm = RC_Q_MC;
                        q = reset_cond.cause;
                    end
                end else begin
                    k = POR_K[i];
                    v = POR_V[i];
                    if (reset_class.bor && i == IDX_TIMER1_CONTROL) begin
                        k = 8'hff;
                    end
                    if (i == IDX_OSC) begin
                        qm = OSC_Q_POR;
                        q = reset_cond.osc;
                    end
                    if (i == IDX_RCAUSE) begin
                        qm = RC_Q_POR;
                        q = reset_cond.cause;
                    end
                end
                regs_d[i] = rst_apply(regs_q[i], v, k, qm, q, IMPL[i]);
            end
            if (irq_wake) begin
                regs_d[IDX_IRQ_FLAGS] = regs_q[IDX_IRQ_FLAGS]
                                        | 8'(8'h01 << wake_irq.src);
            end
            if (vec_high || vec_low) begin
                regs_d[IDX_TOS_U] = {3'b000, pc_now[20:16]};
                regs_d[IDX_TOS_H] = pc_now[15:8];
                regs_d[IDX_TOS_L] = pc_now[7:0];
                regs_d[IDX_STK] = {3'b000,
                                   5'(regs_q[IDX_STK][4:0] + 5'd1)};
                pc_load_d = 1'b1;
                pc_vector_d = vec_high ? VEC_HIGH : VEC_LOW;
            end
        end else if (access_wr && int'(idx) != IDX_PA_PINS) begin
            v = apb_req.pwdata[7:0] & IMPL[idx];
            if (int'(idx) == IDX_PA_LAT || int'(idx) == IDX_PA_DIR) begin
                // Freed bits keep their old value while absent
                v = (v & pa_mask(pins_free))
                    | (regs_q[idx] & ~pa_mask(pins_free));
            end
            regs_d[idx] = v;
        end
    end

    always_comb begin
        prdata_d = prdata_q;
        if (setup_rd) begin
            prdata_d = 32'h00000000;
            if (idx_ok) begin
                prdata_d = {24'h000000,
                            rd_val(regs_q, int'(idx), port_a_in,
                                   pins_free)};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Bits documented as unknown start at zero here
            regs_q <= POR_V;
            prdata_q <= 32'h00000000;
            pc_load_q <= 1'b0;
            pc_vector_q <= 21'h000000;
        end else begin
            regs_q <= regs_d;
            prdata_q <= prdata_d;
            pc_load_q <= pc_load_d;
            pc_vector_q <= pc_vector_d;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_irq_wake_en;
        vec_high || vec_low;
    endsequence

    sequence s_push_done;
        regs_q[IDX_STK][4:0] == 5'($past(regs_q[IDX_STK][4:0]) + 5'd1)
        && regs_q[IDX_TOS_L] == $past(pc_now[7:0]);
    endsequence

    sequence s_rd_timer2_control;
        setup_rd && idx == 6'(IDX_TIMER2_CONTROL);
    endsequence

    sequence s_rd_lat_bound;
        setup_rd && idx == 6'(IDX_PA_LAT) && !pins_free;
    endsequence

    sequence s_por_only;
        reset_class == 4'b1000;
    endsequence

    sequence s_master_clear_pin_only;
        reset_class == 4'b0010;
    endsequence

    pr2_wake_a: assert property (
        reset_class.wake |=> regs_q[IDX_PR2] == 8'hff)
        else $error("period register not all ones after wake");

    t0con_load_a: assert property (
        (reset_class.por || reset_class.master_clear_pin)
        |=> regs_q[IDX_T0CON] == 8'hff)
        else $error("timer 0 control not all ones after reset");

    bank_hold_a: assert property (
        reset_class.wake |=> $stable(regs_q[IDX_BSR]))
        else $error("bank select changed on wake");

    vector_high_a: assert property (
        vec_high |=> pc_load_q && pc_vector_q == VEC_HIGH
        ##1 !pc_load_q)
        else $error("high vector not loaded for one cycle");

    stack_push_a: assert property (
        s_irq_wake_en |=> s_push_done)
        else $error("stack not pushed on interrupt wake");

    flag_set_a: assert property (
        irq_wake |=> regs_q[IDX_IRQ_FLAGS] != 8'h00)
        else $error("no wake source flag set");

    unimpl_read_a: assert property (
        s_rd_timer2_control |=> prdata_q[31:7] == 25'h0)
        else $error("unimplemented bits read nonzero");

    port_a_pins_mask_a: assert property (
        s_rd_lat_bound |=> prdata_q[7:6] == 2'b00)
        else $error("bound port A bits read nonzero");

    bor_keep_a: assert property (
        reset_class.bor |=> $stable(regs_q[IDX_TIMER1_CONTROL]))
        else $error("power-on-only register changed on brown-out");

    osc_cond_a: assert property (
        reset_class.master_clear_pin && !reset_class.wake |=> regs_q[IDX_OSC]
        == {6'b010000, $past(reset_cond.osc[1]), 1'b0})
        else $error("oscillator control pattern wrong");

    hlvd_load_a: assert property (
        reset_class.por && !reset_class.wake
        |=> regs_q[IDX_HLVD] == 8'h05)
        else $error("voltage detect pattern wrong");

    alu_keep_a: assert property (
        (reset_class.master_clear_pin || reset_class.wake)
        |=> $stable(regs_q[IDX_ALU]))
        else $error("arithmetic flags changed by reset");

    vector_low_a: assert property (
        vec_low |=> pc_load_q && pc_vector_q == VEC_LOW
        ##1 !pc_load_q)
        else $error("low vector not loaded for one cycle");

    bank_clear_a: assert property (
        (reset_class.por || reset_class.bor || reset_class.master_clear_pin)
        && !reset_class.wake |=> regs_q[IDX_BSR] == 8'h00)
        else $error("bank select not cleared by reset");

    timer2_control_clear_a: assert property (
        (reset_class.por || reset_class.bor || reset_class.master_clear_pin)
        && !reset_class.wake |=> regs_q[IDX_TIMER2_CONTROL] == 8'h00)
        else $error("timer 2 control not cleared by reset");

    timer1_control_por_a: assert property (
        s_por_only |=> regs_q[IDX_TIMER1_CONTROL] == 8'h00)
        else $error("timer 1 control not cleared on power-on");

    timer1_control_master_clear_pin_a: assert property (
        s_master_clear_pin_only |=> regs_q[IDX_TIMER1_CONTROL]
        == ($past(regs_q[IDX_TIMER1_CONTROL]) & 8'hbf))
        else $error("timer 1 control wrong after master clear");

    osc_por_a: assert property (
        s_por_only |=> regs_q[IDX_OSC]
        == {4'b0100, $past(reset_cond.osc[3]), 3'b000})
        else $error("oscillator control wrong after power-on");

    cause_por_a: assert property (
        s_por_only |=> regs_q[IDX_RCAUSE] == {1'b0,
        $past(reset_cond.cause[6]), 4'b0111, $past(reset_cond.cause[1]),
        1'b0})
        else $error("reset cause wrong after power-on");

    cause_gap_a: assert property (
        any_class |=> regs_q[IDX_RCAUSE][5] == 1'b0)
        else $error("absent reset cause bit set");

    t0con_wake_a: assert property (
        reset_class.wake |=> $stable(regs_q[IDX_T0CON]))
        else $error("timer 0 control changed on wake");

endmodule // reset_state_register_bank

// *** design/reset_bank_pkg.sv ***
// Constants, tables and carrier types for the reset-state register bank
package reset_bank_pkg;
    localparam int NREG = 38;
    localparam int ADDR_W = 8;
    // Register indices; byte address is four times the index
    localparam int IDX_BSR = 2;
    localparam int IDX_ALU = 5;
    localparam int IDX_T0CON = 8;
    localparam int IDX_OSC = 9;
    localparam int IDX_HLVD = 10;
    localparam int IDX_RCAUSE = 12;
    localparam int IDX_TIMER1_CONTROL = 15;
    localparam int IDX_PR2 = 17;
    localparam int IDX_TIMER2_CONTROL = 18;
    localparam int IDX_IRQ_CTL = 24;
    localparam int IDX_IRQ_FLAGS = 25;
    localparam int IDX_PA_LAT = 26;
    localparam int IDX_PA_DIR = 27;
    localparam int IDX_PA_PINS = 28;
    localparam int IDX_TOS_U = 29;
    localparam int IDX_TOS_H = 30;
    localparam int IDX_TOS_L = 31;
    localparam int IDX_STK = 32;
    localparam int IDX_IND_FIRST = 33;
    localparam int GIE_H_BIT = 7;
    localparam int GIE_L_BIT = 6;
    localparam logic [7:0] PA_FREE_MASK = 8'hc0;
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    localparam logic [7:0] OSC_Q_POR = 8'h08;
    localparam logic [7:0] OSC_Q_MC = 8'h02;
    localparam logic [7:0] OSC_Q_WK = 8'h02;
    localparam logic [7:0] RC_Q_POR = 8'h42;
    localparam logic [7:0] RC_Q_MC = 8'h5c;
    localparam logic [7:0] RC_Q_WK = 8'h4c;
    typedef logic [7:0] bank_t [NREG];
    localparam bank_t IMPL = '{
        8'h0f, 8'hff, 8'h0f, 8'h0f, 8'hff, 8'h1f, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hbf, 8'h01, 8'hdf, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hc0, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff,
        8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam bank_t POR_V = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hff, 8'h40, 8'h05, 8'h00, 8'h1c, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam bank_t POR_K = '{
        8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam bank_t MC_K = '{
        8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'hff, 8'hff, 8'hbf,
        8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic por;
        logic bor;
        logic master_clear_pin;
        logic wake;
    } reset_class_t;
    typedef struct packed {
        logic [7:0] osc;
        logic [7:0] cause;
    } reset_cond_t;
    typedef struct packed {
        logic valid;
        logic high;
        logic [2:0] src;
    } wake_irq_t;
endpackage

// *** tb/reset_state_register_bank_tb_top.sv ***
// Self-checking testbench for the reset-state register bank
`timescale 1ns/1ns
module reset_state_register_bank_tb_top;
    import reset_bank_pkg::*;
    logic pclk;
    logic presetn;
    apb_req_t apb_req;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    reset_class_t reset_class;
    reset_cond_t reset_cond;
    wake_irq_t wake_irq;
    logic [20:0] pc_now;
    logic pins_free;
    logic [7:0] port_a_in;
    logic pc_load;
    logic [20:0] pc_vector;
    logic [7:0] lat_out;
    logic [7:0] dir_out;
    int n_mismatch;
    int compares;
    logic [15:0] seed;
    logic [65:0] expq[$];
    logic [7:0] v [NREG];
    logic [7:0] osc_v;
    logic [7:0] rc_v;
    logic [7:0] q_osc;
    logic [7:0] q_rc;
    logic [20:0] pcv;
    int wr_idx [21] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 11, 13, 14, 15, 16, 17, 18,
        19, 20, 21, 22, 23};

    reset_state_register_bank dut (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(apb_req),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .reset_class(reset_class),
        .reset_cond(reset_cond),
        .wake_irq(wake_irq),
        .pc_now(pc_now),
        .pins_free(pins_free),
        .port_a_in(port_a_in),
        .pc_load(pc_load),
        .pc_vector(pc_vector),
        .port_a_latch_out(lat_out),
        .port_a_dir_out(dir_out)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    function automatic logic [7:0] rnd8();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction

    function automatic logic [7:0] wmask(int i);
        case (i)
            0, 2, 3: return 8'h0f;
            5: return 8'h1f;
            11: return 8'h01;
            18: return 8'h7f;
            default: return 8'hff;
        endcase
    endfunction

    // Class c: 0 power-on, 1 brown-out, 2 master clear, 3 wake-up
    function automatic logic [7:0] after(int i, int c, logic [7:0] x);
        case (i)
            2, 6, 11, 16, 18, 20, 21, 22, 23: return (c == 3) ? x : 8'h00;
            8: return (c == 3) ? x : 8'hff;
            15: return (c == 1 || c == 3) ? x : (c == 2) ? x & 8'hbf : 8'h00;
            17: return 8'hff;
            default: return x;
        endcase
    endfunction

    task automatic test_done();
        $display("Counts: %0d mismatches, %0d compares", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read results are judged where they appear, against the oldest note
    always @(posedge pclk) begin
        logic [65:0] e;
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite
                && pready === 1'b1) begin
            if (expq.size() == 0) begin
                n_mismatch++;
                $display("mismatch at %0t: read %h with no note", $time, prdata);
            end else begin
                e = expq.pop_front();
                chk({pslverr, prdata} & e[65:33], e[32:0]);
            end
        end
    end

    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d, input logic [65:0] e);
        int t;
        @(posedge pclk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        if (!wr)
            expq.push_back(e);
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input int i, input logic [7:0] d);
        xfer(1'b1, 8'(i * 4), {24'h0, d}, '0);
    endtask

    task automatic rd(input int i, input logic [7:0] e,
            input logic [7:0] m = 8'hff);
        xfer(1'b0, 8'(i * 4), '0, {9'h1ff, 16'hffff, m, 25'h0, e & m});
    endtask

    task automatic pulse(input int c, input logic vld, input logic hi);
        @(posedge pclk);
        q_osc = rnd8();
        q_rc = rnd8();
        reset_cond <= {q_osc, q_rc};
        reset_class <= 4'b1000 >> c;
        wake_irq <= {vld, hi, 3'd3};
        pc_now <= pcv;
        @(posedge pclk);
        reset_class <= '0;
        wake_irq <= '0;
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        test_done();
    end

    initial begin
        logic [7:0] pa;
        apb_req = '0;
        reset_class = '0;
        reset_cond = '0;
        wake_irq = '0;
        pc_now = '0;
        pins_free = 1'b1;
        port_a_in = 8'h00;
        presetn = 1'b0;
        n_mismatch = 0;
        compares = 0;
        seed = 16'h0010;
        osc_v = 8'h40;
        rc_v = 8'h1c;
        v = '{default: 8'h00};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_BSR, 8'h00);
        rd(IDX_T0CON, 8'hff);
        rd(IDX_OSC, 8'h40);
        rd(IDX_HLVD, 8'h05);
        rd(IDX_RCAUSE, 8'h1c);
        rd(IDX_PR2, 8'hff);
        for (int i = IDX_IND_FIRST; i < NREG; i++) rd(i, 8'h00);
        xfer(1'b0, 8'(NREG * 4), '0, {33'h1ffffffff, 33'h100000000});
        xfer(1'b0, 8'h09, '0, {33'h1ffffffff, 33'h100000000});
        for (int c = 0; c < 4; c++) begin
            foreach (wr_idx[k]) begin
                v[wr_idx[k]] = rnd8();
                wr(wr_idx[k], v[wr_idx[k]]);
            end
            wr(IDX_IRQ_CTL, 8'h80);
            pcv = 21'({rnd8(), rnd8(), rnd8()});
            pulse(c, c == 3, 1'b1);
            chk({32'h0, pc_load}, {32'h0, c == 3});
            if (c == 3)
                chk({12'h0, pc_vector}, {12'h0, VEC_HIGH});
            @(posedge pclk);
            #1 chk({32'h0, pc_load}, 33'h0);
            osc_v = (c < 2) ? 8'h40 | (q_osc & 8'h08) : (c == 2) ?
                8'h40 | (q_osc & 8'h02) : (osc_v & 8'hfd) | (q_osc & 8'h02);
            rc_v = (c < 2) ? 8'h1c | (q_rc & 8'h42) : (c == 2) ?
                (rc_v & 8'h03) | (q_rc & 8'h5c) : (rc_v & 8'h93) | (q_rc & 8'h4c);
            foreach (wr_idx[k])
                rd(wr_idx[k], after(wr_idx[k], c, v[wr_idx[k]])
                    & wmask(wr_idx[k]));
            rd(IDX_OSC, osc_v);
            rd(IDX_RCAUSE, rc_v);
            rd(IDX_HLVD, 8'h05);
        end
        rd(IDX_IRQ_FLAGS, 8'h08, 8'h08);
        rd(IDX_TOS_U, {3'h0, pcv[20:16]});
        rd(IDX_TOS_H, pcv[15:8]);
        rd(IDX_TOS_L, pcv[7:0]);
        rd(IDX_STK, 8'h01);
        // Low-priority wake while only the high enable is set: no vector
        pulse(3, 1'b1, 1'b0);
        chk({32'h0, pc_load}, 33'h0);
        rd(IDX_STK, 8'h01);
        // Low-priority enable set: the low vector is taken and pushed
        wr(IDX_IRQ_CTL, 8'h40);
        pulse(3, 1'b1, 1'b0);
        chk({32'h0, pc_load}, 33'h1);
        chk({12'h0, pc_vector}, {12'h0, VEC_LOW});
        rd(IDX_STK, 8'h02);
        wr(IDX_PA_LAT, 8'hff);
        wr(IDX_PA_DIR, 8'hff);
        rd(IDX_PA_LAT, 8'hff);
        pa = rnd8();
        @(posedge pclk);
        pins_free <= 1'b0;
        port_a_in <= pa;
        rd(IDX_PA_LAT, 8'h3f);
        rd(IDX_PA_DIR, 8'h3f);
        rd(IDX_PA_PINS, pa & 8'h3f);
        chk({25'h0, lat_out}, {25'h0, 8'h3f});
        chk({25'h0, dir_out}, {25'h0, 8'h3f});
        wr(IDX_PA_LAT, 8'h00);
        @(posedge pclk);
        pins_free <= 1'b1;
        rd(IDX_PA_PINS, pa);
        rd(IDX_PA_LAT, 8'hc0);
        repeat (2) @(posedge pclk);
        test_done();
    end
endmodule // reset_state_register_bank_tb_top
